/* File: rtl/tos_pkg.sv */
// Shared constants and types of the transfer output select block
package tos_pkg;

  // ==========================================================================
  // Register map (byte addresses on the Avalon-MM slave)
  localparam logic [4:0] TOS_ADDR_CFG    = 5'h00;
  localparam logic [4:0] TOS_ADDR_UPPER  = 5'h04;
  localparam logic [4:0] TOS_ADDR_LOWER  = 5'h08;
  localparam logic [4:0] TOS_ADDR_STATUS = 5'h0c;
  localparam logic [4:0] TOS_ADDR_VALUE  = 5'h10;

  // ==========================================================================
  // Configuration register fields
  localparam int TOS_CFG_SEL_LSB   = 0;   // 3 bits, source select
  localparam int TOS_CFG_REMOTE    = 3;   // Setpoint mode is remote
  localparam int TOS_CFG_CTRL_LSB  = 4;   // 2 bits, control type
  localparam int TOS_CFG_POT       = 6;   // Potentiometer input fitted
  localparam int TOS_CFG_HAS_XFER  = 7;   // Dedicated transfer output fitted
  localparam int TOS_CFG_OUT1_LIN  = 8;   // Control output 1 is current/linear voltage
  localparam int TOS_CFG_OUT2_LIN  = 9;   // Control output 2 is current/linear voltage
  localparam int TOS_CFG_TEMP_IN   = 10;  // Input is temperature, else analog
  localparam int TOS_CFG_W         = 11;
  localparam logic [10:0] TOS_CFG_RESET = 11'h000;

  // ==========================================================================
  // Status register fields
  localparam int TOS_ST_ROUTE_LSB  = 0;   // 2 bits, output destination
  localparam int TOS_ST_SEL_OFF    = 2;   // Source select is offered
  localparam int TOS_ST_LIM_OFF    = 3;   // Limits are offered
  localparam int TOS_ST_ACTIVE     = 4;   // Effective source is not off
  localparam int TOS_ST_REJECT     = 5;   // Last configuration or limit write was refused

  // ==========================================================================
  // Percent quantities are signed tenths of a percent
  localparam logic signed [15:0] TOS_PCT_0      = 16'sh0000;  //    0.0
  localparam logic signed [15:0] TOS_PCT_100    = 16'sh03e8;  //  100.0
  localparam logic signed [15:0] TOS_PCT_105    = 16'sh041a;  //  105.0
  localparam logic signed [15:0] TOS_PCT_M5     = -16'sh0032; //   -5.0
  localparam logic signed [15:0] TOS_PCT_M10    = -16'sh0064; //  -10.0
  localparam logic signed [15:0] TOS_PCT_110    = 16'sh044c;  //  110.0

  // ==========================================================================
  // Enumerations
  typedef enum logic [2:0] {
    TOS_SRC_OFF,
    TOS_SRC_SETPOINT,
    TOS_SRC_PV,
    TOS_SRC_MV_HEAT,
    TOS_SRC_MV_COOL,
    TOS_SRC_VALVE
  } tos_src_type;

  typedef enum logic [1:0] {
    TOS_CTRL_STANDARD,
    TOS_CTRL_HEAT_COOL,
    TOS_CTRL_POS_PROP,
    TOS_CTRL_SPARE
  } tos_ctrl_type;

  typedef enum logic [1:0] {
    TOS_ROUTE_NONE,
    TOS_ROUTE_XFER,
    TOS_ROUTE_OUT1,
    TOS_ROUTE_OUT2
  } tos_route_type;

endpackage

/* File: rtl/tos_lim_if.sv */
// Carrier of the allowed range and default limits for the selected source
`timescale 1ns/1ns
interface tos_lim_if;
  logic signed [15:0] min_v;
  logic signed [15:0] max_v;
  logic signed [15:0] def_lo;
  logic signed [15:0] def_hi;

  modport prov (output min_v, output max_v, output def_lo, output def_hi);
  modport cons (input  min_v, input  max_v, input  def_lo, input  def_hi);
endinterface

/* File: rtl/tos_limits.sv */
// Range and default table of the transfer limits, per selected source
`timescale 1ns/1ns
module tos_limits
  import tos_pkg::*;
(
  input  wire tos_src_type        sel_i,
  input  wire tos_ctrl_type       ctrl_i,
  input  wire logic               temp_in_i,
  input  wire logic signed [15:0] sp_lo_i,
  input  wire logic signed [15:0] sp_hi_i,
  input  wire logic signed [15:0] in_lo_i,
  input  wire logic signed [15:0] in_hi_i,
  input  wire logic signed [15:0] sc_lo_i,
  input  wire logic signed [15:0] sc_hi_i,
  tos_lim_if.prov                 lim
);

  always_comb begin
    lim.min_v  = TOS_PCT_0;
    lim.max_v  = TOS_PCT_105;
    lim.def_lo = TOS_PCT_0;
    lim.def_hi = TOS_PCT_100;
    case (sel_i)
      TOS_SRC_SETPOINT: begin
        lim.min_v  = sp_lo_i;
        lim.max_v  = sp_hi_i;
        lim.def_lo = sp_lo_i;
        lim.def_hi = sp_hi_i;
      end
      TOS_SRC_PV: begin
        if (temp_in_i) begin
          lim.min_v  = in_lo_i;
          lim.max_v  = in_hi_i;
          lim.def_lo = in_lo_i;
          lim.def_hi = in_hi_i;
        end else begin
          lim.min_v  = sc_lo_i;
          lim.max_v  = sc_hi_i;
          lim.def_lo = sc_lo_i;
          lim.def_hi = sc_hi_i;
        end
      end
      TOS_SRC_MV_HEAT: begin
        lim.min_v = (ctrl_i == TOS_CTRL_STANDARD) ? TOS_PCT_M5 : TOS_PCT_0;
      end
      TOS_SRC_VALVE: begin
        lim.min_v = TOS_PCT_M10;
        lim.max_v = TOS_PCT_110;
      end
      default: begin
        lim.min_v = TOS_PCT_0;
      end
    endcase
  end

endmodule

/* File: rtl/tos_scaler.sv */
// Linear map of a source value between two limits onto the output span
`timescale 1ns/1ns
module tos_scaler #(
  parameter int OUT_W = 12
) (
  input  wire logic signed [15:0] value_i,
  input  wire logic signed [15:0] lower_i,
  input  wire logic signed [15:0] upper_i,
  output logic        [OUT_W-1:0] code_o
);

  localparam logic signed [47:0] FULL = 48'sd1 <<< OUT_W;

  logic signed [47:0] num;
  logic signed [47:0] den;
  logic signed [47:0] quo;

  if (OUT_W < 4 || OUT_W > 24) begin : g_out_w_check
    $error("tos_scaler: OUT_W out of range");
  end

  // Inverted limits are allowed: the span then runs backwards
  always_comb begin
    num = (48'(value_i) - 48'(lower_i)) * (FULL - 48'sd1);
    den = 48'(upper_i) - 48'(lower_i);
    quo = (den == 48'sd0) ? 48'sd0 : num / den;
    if (quo < 48'sd0) begin
      code_o = '0;
    end else if (quo > FULL - 48'sd1) begin
      code_o = '1;
    end else begin
      code_o = quo[OUT_W-1:0];
    end
  end

endmodule

/* File: rtl/tos_top.sv */
// Transfer output source select, routing and scaling with Avalon-MM registers
//
// Operation
// - Source selector picks off, setpoint, PV, heat MV, cool MV or valve; resets off.
// - Selector is offered only with transfer, current or linear voltage output.
// - Route to transfer output, else linear output 1, else linear output 2, else none.
// - Limits are offered only when an output exists and source is not off.
// - Separate upper and lower limits define the source values at span ends.
// - PV with temperature input: limits span input range, default to its ends.
// - PV with analog input: limits span analog scaling, default to scaling limits.
// - Setpoint source in remote setpoint mode outputs the remote setpoint.
// - Heat MV limits -5.0..105.0 standard, 0.0..105.0 heat/cool; ignored position-proportional.
// - Cool MV limits 0.0..105.0; ignored under any control type but heat/cool.
// - Valve limits -10.0..110.0; selectable only position-proportional with potentiometer.
`timescale 1ns/1ns
module tos_top
  import tos_pkg::*;
#(
  parameter int OUT_W = 12
) (
  input  wire logic               clock_i,
  input  wire logic               rstn_i,
  input  wire logic [4:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  input  wire logic [3:0]         avs_byteenable_i,
  output logic      [31:0]        avs_readdata_o,
  output logic                    avs_waitrequest_o,
  input  wire logic signed [15:0] sp_local_i,
  input  wire logic signed [15:0] sp_remote_i,
  input  wire logic signed [15:0] pv_i,
  input  wire logic signed [15:0] mv_heat_i,
  input  wire logic signed [15:0] mv_cool_i,
  input  wire logic signed [15:0] valve_i,
  input  wire logic signed [15:0] sp_lo_i,
  input  wire logic signed [15:0] sp_hi_i,
  input  wire logic signed [15:0] in_lo_i,
  input  wire logic signed [15:0] in_hi_i,
  input  wire logic signed [15:0] sc_lo_i,
  input  wire logic signed [15:0] sc_hi_i,
  output logic      [OUT_W-1:0]   xfer_value_o,
  output logic      [OUT_W-1:0]   out1_value_o,
  output logic      [OUT_W-1:0]   out2_value_o,
  output logic      [1:0]         route_o
);

  if (OUT_W < 4 || OUT_W > 24) begin : g_out_w_check
    $error("tos_top: OUT_W out of range");
  end

  if (TOS_CFG_TEMP_IN >= TOS_CFG_W) begin : g_cfg_w_check
    $error("tos_top: configuration register too narrow");
  end

  // ==========================================================================
  // State
  logic [TOS_CFG_W-1:0] cfg_q;
  tos_src_type          sel_q;
  logic signed [15:0]   upper_q;
  logic signed [15:0]   lower_q;
  logic                 load_def_q;
  logic                 reject_q;
  logic                 wait_q;
  logic [31:0]          rdata_q;
  logic [OUT_W-1:0]     code_q;
  tos_route_type        route_q;

  // ==========================================================================
  // Decoded configuration
  tos_ctrl_type  ctrl;
  tos_route_type route_d;
  tos_src_type   wr_sel;
  logic          sel_offered;
  logic          lim_offered;
  logic          wr_sel_legal;
  logic          eff_active;
  logic          bus_take;
  logic          wr_en;
  logic signed [15:0] wr_val;
  logic signed [15:0] src_val;
  logic [OUT_W-1:0]   scaled;

  tos_lim_if lim ();

  assign ctrl = tos_ctrl_type'(cfg_q[TOS_CFG_CTRL_LSB +: 2]);

  always_comb begin
    if (cfg_q[TOS_CFG_HAS_XFER]) begin
      route_d = TOS_ROUTE_XFER;
    end else if (cfg_q[TOS_CFG_OUT1_LIN]) begin
      route_d = TOS_ROUTE_OUT1;
    end else if (cfg_q[TOS_CFG_OUT2_LIN]) begin
      route_d = TOS_ROUTE_OUT2;
    end else begin
      route_d = TOS_ROUTE_NONE;
    end
  end

  assign sel_offered = (route_d != TOS_ROUTE_NONE);
  assign lim_offered = sel_offered && (sel_q != TOS_SRC_OFF);

  // A source that the model cannot serve is carried as off
  always_comb begin
    case (sel_q)
      TOS_SRC_OFF:     eff_active = 1'b0;
      TOS_SRC_MV_HEAT: eff_active = (ctrl != TOS_CTRL_POS_PROP);
      TOS_SRC_MV_COOL: eff_active = (ctrl == TOS_CTRL_HEAT_COOL);
      TOS_SRC_VALVE:   eff_active = (ctrl == TOS_CTRL_POS_PROP) && cfg_q[TOS_CFG_POT];
      default:         eff_active = 1'b1;
    endcase
  end

  // Legality of a newly written select, judged against the current model bits
  assign wr_sel = tos_src_type'(avs_writedata_i[TOS_CFG_SEL_LSB +: 3]);
  always_comb begin
    case (wr_sel)
      TOS_SRC_OFF,
      TOS_SRC_SETPOINT,
      TOS_SRC_PV,
      TOS_SRC_MV_HEAT,
      TOS_SRC_MV_COOL: wr_sel_legal = 1'b1;
      TOS_SRC_VALVE:   wr_sel_legal = (ctrl == TOS_CTRL_POS_PROP) && cfg_q[TOS_CFG_POT];
      default:         wr_sel_legal = 1'b0;
    endcase
  end

  always_comb begin
    case (sel_q)
      TOS_SRC_SETPOINT: src_val = cfg_q[TOS_CFG_REMOTE] ? sp_remote_i : sp_local_i;
      TOS_SRC_PV:       src_val = pv_i;
      TOS_SRC_MV_HEAT:  src_val = mv_heat_i;
      TOS_SRC_MV_COOL:  src_val = mv_cool_i;
      TOS_SRC_VALVE:    src_val = valve_i;
      default:          src_val = 16'sh0000;
    endcase
  end

  tos_limits u_limits (
    .sel_i     (sel_q),
    .ctrl_i    (ctrl),
    .temp_in_i (cfg_q[TOS_CFG_TEMP_IN]),
    .sp_lo_i   (sp_lo_i),
    .sp_hi_i   (sp_hi_i),
    .in_lo_i   (in_lo_i),
    .in_hi_i   (in_hi_i),
    .sc_lo_i   (sc_lo_i),
    .sc_hi_i   (sc_hi_i),
    .lim       (lim)
  );

  tos_scaler #(
    .OUT_W (OUT_W)
  ) u_scaler (
    .value_i (src_val),
    .lower_i (lower_q),
    .upper_i (upper_q),
    .code_o  (scaled)
  );

  // ==========================================================================
  // Avalon-MM handshake: one wait state, then a single low waitrequest cycle
  assign bus_take = (avs_read_i || avs_write_i) && wait_q;
  assign wr_en    = avs_write_i && !wait_q && (avs_byteenable_i != 4'h0);
  assign wr_val   = avs_writedata_i[15:0];

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !bus_take;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_take && avs_read_i) begin
      if (avs_address_i == TOS_ADDR_CFG) begin
        rdata_q <= {21'h00_0000, cfg_q[TOS_CFG_W-1:3], sel_q};
      end else if (avs_address_i == TOS_ADDR_UPPER) begin
        rdata_q <= {{16{upper_q[15]}}, upper_q};
      end else if (avs_address_i == TOS_ADDR_LOWER) begin
        rdata_q <= {{16{lower_q[15]}}, lower_q};
      end else if (avs_address_i == TOS_ADDR_STATUS) begin
        rdata_q <= {26'h000_0000, reject_q, eff_active, lim_offered, sel_offered, route_q};
      end else if (avs_address_i == TOS_ADDR_VALUE) begin
        rdata_q <= 32'(code_q);
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // Configuration and source select
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_q <= TOS_CFG_RESET;
    end else if (wr_en && avs_address_i == TOS_ADDR_CFG) begin
      cfg_q <= avs_writedata_i[TOS_CFG_W-1:0];
    end
  end

  // A select written with the model bits is judged on the old bits
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_q <= TOS_SRC_OFF;
    end else if (wr_en && avs_address_i == TOS_ADDR_CFG) begin
      if (sel_offered && wr_sel_legal) begin
        sel_q <= wr_sel;
      end
    end else if (!sel_offered) begin
      sel_q <= TOS_SRC_OFF;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reject_q <= 1'b0;
    end else if (wr_en && avs_address_i == TOS_ADDR_CFG) begin
      reject_q <= !(sel_offered && wr_sel_legal);
    end else if (wr_en && (avs_address_i == TOS_ADDR_UPPER ||
                           avs_address_i == TOS_ADDR_LOWER)) begin
      reject_q <= !lim_offered || wr_val < lim.min_v || wr_val > lim.max_v;
    end
  end

  // ==========================================================================
  // Limits: defaults load the cycle after a written select changes the source
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      load_def_q <= 1'b0;
    end else begin
      load_def_q <= wr_en && avs_address_i == TOS_ADDR_CFG && sel_offered &&
                    wr_sel_legal && (wr_sel != sel_q);
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      upper_q <= TOS_PCT_100;
      lower_q <= TOS_PCT_0;
    end else if (load_def_q) begin
      upper_q <= lim.def_hi;
      lower_q <= lim.def_lo;
    end else if (wr_en && lim_offered && wr_val >= lim.min_v && wr_val <= lim.max_v) begin
      if (avs_address_i == TOS_ADDR_UPPER) begin
        upper_q <= wr_val;
      end else if (avs_address_i == TOS_ADDR_LOWER) begin
        lower_q <= wr_val;
      end
    end
  end

  // ==========================================================================
  // Output code and routing
  // An ignored source shows the bottom of the span
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      code_q <= '0;
    end else begin
      code_q <= eff_active ? scaled : '0;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      route_q <= TOS_ROUTE_NONE;
    end else begin
      route_q <= route_d;
    end
  end

  // Only the routed output carries the code; the others rest at span minimum
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xfer_value_o <= '0;
    end else begin
      xfer_value_o <= (route_q == TOS_ROUTE_XFER) ? code_q : '0;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out1_value_o <= '0;
    end else begin
      out1_value_o <= (route_q == TOS_ROUTE_OUT1) ? code_q : '0;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out2_value_o <= '0;
    end else begin
      out2_value_o <= (route_q == TOS_ROUTE_OUT2) ? code_q : '0;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign route_o           = route_q;

endmodule

/* File: dv/tos_top_sva.sv */
// Concurrent checks on the ports of the transfer output select block
`timescale 1ns/1ns
module tos_top_sva
  import tos_pkg::*;
#(
  parameter int OUT_W = 12
) (
  input wire logic             clock_i,
  input wire logic             rstn_i,
  input wire logic             avs_read_i,
  input wire logic             avs_write_i,
  input wire logic [31:0]      avs_readdata_o,
  input wire logic             avs_waitrequest_o,
  input wire logic [OUT_W-1:0] xfer_value_o,
  input wire logic [OUT_W-1:0] out1_value_o,
  input wire logic [OUT_W-1:0] out2_value_o,
  input wire logic [1:0]       route_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  // ==========================================================================
  // Bus handshake
  a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("request not answered after one wait state");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_idle_quiet: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o
    |=> avs_waitrequest_o) else $error("answer without a request");
  // Read data may only move at the edge that ends the wait state of a read
  a_rdata_hold: assert property ($changed(avs_readdata_o)
    |-> avs_read_i && !avs_waitrequest_o) else $error("read data moved without a read");

  // ==========================================================================
  // Only the routed output carries a code; three cycles allow for the output flop
  a_none_silent: assert property ((route_o == TOS_ROUTE_NONE) [*3]
    |-> xfer_value_o == '0 && out1_value_o == '0 && out2_value_o == '0)
    else $error("output driven with no route");
  a_xfer_alone: assert property ((route_o == TOS_ROUTE_XFER) [*3]
    |-> out1_value_o == '0 && out2_value_o == '0) else $error("control output driven");
  a_out1_alone: assert property ((route_o == TOS_ROUTE_OUT1) [*3]
    |-> xfer_value_o == '0 && out2_value_o == '0) else $error("wrong output driven");
  a_out2_alone: assert property ((route_o == TOS_ROUTE_OUT2) [*3]
    |-> xfer_value_o == '0 && out1_value_o == '0) else $error("wrong output driven");
endmodule

bind tos_top tos_top_sva #(.OUT_W(OUT_W)) tos_top_sva_i (
  .clock_i(clock_i), .rstn_i(rstn_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .xfer_value_o(xfer_value_o), .out1_value_o(out1_value_o),
  .out2_value_o(out2_value_o), .route_o(route_o));

/* File: dv/tos_recorder.sv */
// Analogue recorder model: follows whichever output the block routes the value to
`timescale 1ns/1ns
module tos_recorder
  import tos_pkg::*;
#(
  parameter int OUT_W = 12
) (
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  input  wire logic [1:0]       route_i,
  input  wire logic [OUT_W-1:0] xfer_i,
  input  wire logic [OUT_W-1:0] out1_i,
  input  wire logic [OUT_W-1:0] out2_i,
  output logic      [OUT_W-1:0] level_o
);
  // A recorder with nothing wired reads the bottom of its span
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) level_o <= '0;
    else begin
      case (route_i)
        TOS_ROUTE_XFER: level_o <= xfer_i;
        TOS_ROUTE_OUT1: level_o <= out1_i;
        TOS_ROUTE_OUT2: level_o <= out2_i;
        default:        level_o <= '0;
      endcase
    end
  end
endmodule

/* File: dv/tos_top_tb_top.sv */
// Self-checking bench of the transfer output select block
`timescale 1ns/1ns
module tos_top_tb_top;
  import tos_pkg::*;
  localparam int OUT_W = 12;
  localparam int MAXC = (1 << OUT_W) - 1;
  localparam int XF = 32'h80, O1 = 32'h100, O2 = 32'h200, TMP = 32'h400, POT = 32'h40;
  localparam int RMT = 32'h8, HC = 32'h10, PP = 32'h20;
  logic                   clock_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [4:0]             avs_address_i;
  logic [31:0]            avs_writedata_i, avs_readdata_o, q;
  logic [3:0]             avs_byteenable_i;
  logic signed [15:0]     sp_local_i, sp_remote_i, pv_i, mv_heat_i, mv_cool_i, valve_i;
  logic signed [15:0]     sp_lo_i, sp_hi_i, in_lo_i, in_hi_i, sc_lo_i, sc_hi_i;
  logic [OUT_W-1:0]       xfer_value_o, out1_value_o, out2_value_o, level;
  logic [1:0]             route_o;
  int                     err_total, n_checks;

  tos_top #(.OUT_W(OUT_W)) tos_top_i (.clock_i, .rstn_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .sp_local_i, .sp_remote_i, .pv_i, .mv_heat_i, .mv_cool_i, .valve_i, .sp_lo_i, .sp_hi_i,
    .in_lo_i, .in_hi_i, .sc_lo_i, .sc_hi_i, .xfer_value_o, .out1_value_o, .out2_value_o,
    .route_o);
  tos_recorder #(.OUT_W(OUT_W)) tos_recorder_i (.clock_i, .rstn_i, .route_i(route_o),
    .xfer_i(xfer_value_o), .out1_i(out1_value_o), .out2_i(out2_value_o), .level_o(level));

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // Holds the request until waitrequest is seen low, then releases it
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge clock_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input int d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  // Defaults load one edge after the write, the code three more
  task automatic settle();
    repeat (6) @(posedge clock_i);
    #1;
  endtask

  // Model bits go in first so the select is judged against them
  task automatic src(input int m);
    wr(TOS_ADDR_CFG, m & ~7);
    wr(TOS_ADDR_CFG, m);
    settle();
  endtask

  function automatic int code(input int v, input int lo, input int hi);
    int c;
    if (hi == lo) return 0;
    c = (v - lo) * MAXC / (hi - lo);
    return (c < 0) ? 0 : (c > MAXC) ? MAXC : c;
  endfunction

  task automatic lims(input int lo, input int hi);
    rd(TOS_ADDR_LOWER);
    chk(q, lo);
    rd(TOS_ADDR_UPPER);
    chk(q, hi);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rd(TOS_ADDR_CFG);
    chk(q, 32'h0);
    lims(0, 1000);
    chk(route_o, TOS_ROUTE_NONE);
    rd(5'h14);
    chk(q, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_route();
    int m[6] = '{XF, O1 | O2, O1, O2, 0, XF | O1 | O2};
    logic [1:0] r[6] = '{TOS_ROUTE_XFER, TOS_ROUTE_OUT1, TOS_ROUTE_OUT1, TOS_ROUTE_OUT2,
                         TOS_ROUTE_NONE, TOS_ROUTE_XFER};
    for (int i = 0; i < 6; i++) begin
      src(m[i] | TOS_SRC_PV);
      chk(route_o, r[i]);
      rd(TOS_ADDR_CFG);
      chk(q[2:0], (r[i] == TOS_ROUTE_NONE) ? TOS_SRC_OFF : TOS_SRC_PV);
      chk(level, (r[i] == TOS_ROUTE_NONE) ? 0 : code(550, 100, 900));
      rd(TOS_ADDR_STATUS);
      chk(q[2:0], {r[i] != TOS_ROUTE_NONE, r[i]});
      rd(TOS_ADDR_VALUE);
      chk(q, (r[i] == TOS_ROUTE_NONE) ? 0 : code(550, 100, 900));
      if (r[i] != TOS_ROUTE_NONE) lims(100, 900);
    end
    $display("route test done");
  endtask

  task automatic t_limits_off();
    src(XF);
    rd(TOS_ADDR_UPPER);
    wr(TOS_ADDR_UPPER, q + 1);
    rd(TOS_ADDR_STATUS);
    chk(q[5:3], 3'b100);
    $display("limits offered test done");
  endtask

  task automatic t_pv_temp();
    src(XF | TMP | TOS_SRC_PV);
    lims(-200, 1300);
    wr(TOS_ADDR_LOWER, 550);
    settle();
    chk(level, 0);
    wr(TOS_ADDR_LOWER, -200);
    wr(TOS_ADDR_UPPER, 550);
    settle();
    chk(level, MAXC);
    wr(TOS_ADDR_UPPER, 1301);
    rd(TOS_ADDR_STATUS);
    chk(q[5], 1'b1);
    lims(-200, 550);
    avs_byteenable_i <= 4'h0;
    wr(TOS_ADDR_LOWER, 0);
    avs_byteenable_i <= 4'hf;
    lims(-200, 550);
    $display("temperature input test done");
  endtask

  task automatic t_remote();
    src(XF | TOS_SRC_SETPOINT);
    chk(level, code(500, 0, 2000));
    wr(TOS_ADDR_CFG, XF | RMT | TOS_SRC_SETPOINT);
    settle();
    chk(level, code(1500, 0, 2000));
    $display("remote setpoint test done");
  endtask

  task automatic t_heat();
    src(XF | TOS_SRC_MV_HEAT);
    lims(0, 1000);
    chk(level, code(500, 0, 1000));
    wr(TOS_ADDR_LOWER, -50);
    wr(TOS_ADDR_LOWER, -51);
    wr(TOS_ADDR_UPPER, 1051);
    lims(-50, 1000);
    wr(TOS_ADDR_CFG, XF | HC | TOS_SRC_MV_HEAT);
    wr(TOS_ADDR_LOWER, -10);
    lims(-50, 1000);
    wr(TOS_ADDR_CFG, XF | PP | TOS_SRC_MV_HEAT);
    settle();
    rd(TOS_ADDR_STATUS);
    chk(q[4], 1'b0);
    chk(level, 0);
    $display("heating value test done");
  endtask

  task automatic t_cool();
    src(XF | TOS_SRC_MV_COOL);
    rd(TOS_ADDR_STATUS);
    chk(q[4], 1'b0);
    chk(level, 0);
    wr(TOS_ADDR_CFG, XF | HC | TOS_SRC_MV_COOL);
    settle();
    chk(level, code(250, 0, 1000));
    wr(TOS_ADDR_LOWER, -1);
    rd(TOS_ADDR_STATUS);
    chk(q[5:4], 2'b11);
    $display("cooling value test done");
  endtask

  task automatic t_valve();
    src(XF | PP | TOS_SRC_VALVE);
    rd(TOS_ADDR_CFG);
    chk(q[2:0], TOS_SRC_OFF);
    src(XF | PP | POT | TOS_SRC_VALVE);
    lims(0, 1000);
    wr(TOS_ADDR_LOWER, -100);
    wr(TOS_ADDR_LOWER, -101);
    wr(TOS_ADDR_UPPER, 1100);
    lims(-100, 1100);
    settle();
    chk(level, code(300, -100, 1100));
    $display("valve opening test done");
  endtask

  // ==========================================================================
  // Run control
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  initial begin
    #200000;
    err_total++;
    test_done();
  end

  initial begin
    {rstn_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} <= '0;
    avs_byteenable_i <= 4'hf;
    {sp_local_i, sp_remote_i, pv_i} <= {16'sd500, 16'sd1500, 16'sd550};
    {mv_heat_i, mv_cool_i, valve_i} <= {16'sd500, 16'sd250, 16'sd300};
    {sp_lo_i, sp_hi_i, in_lo_i, in_hi_i} <= {16'sd0, 16'sd2000, -16'sd200, 16'sd1300};
    {sc_lo_i, sc_hi_i} <= {16'sd100, 16'sd900};
    repeat (16) @(posedge clock_i);
    rstn_i <= 1'b1;
    t_reset();
    t_route();
    t_limits_off();
    t_pv_temp();
    t_remote();
    t_heat();
    t_cool();
    t_valve();
    test_done();
  end
endmodule
